/* hdl/cepm_params.svh */
`ifndef CEPM_PARAMS_SVH
`define CEPM_PARAMS_SVH
// register byte addresses on the wishbone bus
`define CEPM_ADDR_DIR 8'h04
`define CEPM_ADDR_DATA 8'h10
`define CEPM_ADDR_OPT 8'h20
`define CEPM_ADDR_OPT2 8'h24
// option register field positions
`define CEPM_OPT_CMP1 0
`define CEPM_OPT_CMP2 1
`define CEPM_OPT_AMP 2
`define CEPM_OPT_BIT1_ZERO 3
`define CEPM_OPT_BIT3_ZERO 4
`define CEPM_OPT_GAIN 5
// reset values
`define CEPM_DIR_RST 4'h0
`define CEPM_DATA_RST 4'h0
`define CEPM_OPT_RST 6'h00
`define CEPM_OPT2_RST 8'h00
`endif

/* hdl/cepm_pkg.sv */
package cepm_pkg;
    // wishbone request as one carrier
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cepm_wb_req_type;
    // read selection mode of the port
    typedef enum logic [1:0] {
        CEPM_PLAIN,
        CEPM_CMP,
        CEPM_CMP_AMP,
        CEPM_OTHER
    } cepm_mode_type;
endpackage

/* hdl/cepm_port_read_mux.sv */
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cepm_params.svh"
module cepm_port_read_mux
    import cepm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] ce_pin_i,
    output logic [3:0] ce_pin_o,
    output logic [3:0] ce_pin_oe_o,
    input wire logic cmp1_out_i,
    input wire logic cmp2_out_i,
    input wire logic [3:0] e_wake_edge_i,
    output logic wake_o,
    output logic cmp1_en_o,
    output logic cmp2_en_o,
    output logic amp_en_o,
    output logic gain_boost_o
);
    cepm_wb_req_type req;
    logic [3:0] dir_q, dir_d;
    logic [3:0] data_q, data_d;
    logic [5:0] opt_q, opt_d;
    logic [7:0] opt2_q, opt2_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [3:0] pin_q, pin_d, oe_q, oe_d;
    logic wake_q, wake_d;
    logic [3:0] port_rd;
    logic [3:0] plain_rd;
    logic [3:0] force_high;
    logic [3:0] wake_en;
    cepm_mode_type mode;
    logic wr, rd_go;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                   sel: wb_sel_i, dat: wb_dat_i};
    assign force_high = opt2_q[3:0];
    assign wake_en = opt2_q[7:4];
    // one new request per cycle pair: ack drops the cycle after it is given
    assign rd_go = req.cyc && req.stb && !ack_q;
    assign wr = rd_go && req.we && req.sel[0];
    // reference plain read for the checks below, written per word
    assign plain_rd = (dir_q & data_q) | (~dir_q & ce_pin_i);

    // decode the option combination into a read mode
    // all three together is unsupported and falls back to a plain read
    always_comb
    begin
        if (!opt_q[`CEPM_OPT_CMP1] && !opt_q[`CEPM_OPT_CMP2] && !opt_q[`CEPM_OPT_AMP])
            mode = CEPM_PLAIN;
        else if (opt_q[`CEPM_OPT_CMP1] && opt_q[`CEPM_OPT_AMP] && !opt_q[`CEPM_OPT_CMP2])
            mode = CEPM_CMP_AMP;
        else if (!opt_q[`CEPM_OPT_AMP])
            mode = CEPM_CMP;
        else
            mode = CEPM_OTHER; // amplifier without comparator one, or all three: pins read plainly
    end

    // port read value, per bit pin level or latch by direction
    // substituted bits ignore direction, the comparator owns those pins
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            port_rd[i] = dir_q[i] ? data_q[i] : ce_pin_i[i];
        unique case (mode)
            CEPM_PLAIN, CEPM_OTHER:
            begin
            end
            CEPM_CMP:
            begin
                // pair 0/1 only for comparator one
                if (opt_q[`CEPM_OPT_CMP1])
                begin
                    port_rd[0] = cmp1_out_i;
                    port_rd[1] = opt_q[`CEPM_OPT_BIT1_ZERO] ? 1'b0 : ce_pin_i[1];
                end
                // pair 2/3 only for comparator two
                if (opt_q[`CEPM_OPT_CMP2])
                begin
                    port_rd[2] = cmp2_out_i;
                    port_rd[3] = opt_q[`CEPM_OPT_BIT3_ZERO] ? 1'b0 : ce_pin_i[3];
                end
            end
            CEPM_CMP_AMP:
            begin
                // upper pair zero, bit 0 comparator
                port_rd[0] = cmp1_out_i;
                port_rd[3:2] = 2'h0;
                port_rd[1] = opt_q[`CEPM_OPT_BIT1_ZERO] ? 1'b0 : ce_pin_i[1];
            end
        endcase
    end

    // register file and bus answer next state
    // writes land at the taking edge; the ack rises at that same edge
    // unmapped places are still acked so a stray access never hangs
    always_comb
    begin
        dir_d = dir_q;
        data_d = data_q;
        opt_d = opt_q;
        opt2_d = opt2_q;
        ack_d = rd_go;
        rdat_d = 32'h0000_0000;
        if (wr)
        begin
            unique case (req.adr)
                `CEPM_ADDR_DIR: dir_d = req.dat[3:0];
                `CEPM_ADDR_DATA: data_d = req.dat[3:0];
                `CEPM_ADDR_OPT: opt_d = req.dat[5:0];
                `CEPM_ADDR_OPT2: opt2_d = req.dat[7:0];
                default: ;
            endcase
        end
        if (rd_go && !req.we)
        begin
            unique case (req.adr)
                `CEPM_ADDR_DIR: rdat_d = {28'h0, dir_q};
                `CEPM_ADDR_DATA: rdat_d = {28'h0, port_rd};
                `CEPM_ADDR_OPT: rdat_d = {26'h0, opt_q};
                `CEPM_ADDR_OPT2: rdat_d = {24'h0, opt2_q};
                default: rdat_d = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // pins and wake next state
    always_comb
    begin
        oe_d = dir_q;
        pin_d = data_q | force_high;
        wake_d = |(e_wake_edge_i & wake_en);
    end

    // registers; direction clears to input so nothing drives out of reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dir_q <= `CEPM_DIR_RST;
            data_q <= `CEPM_DATA_RST;
            opt_q <= `CEPM_OPT_RST;
            opt2_q <= `CEPM_OPT2_RST;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            pin_q <= 4'h0;
            oe_q <= 4'h0;
            wake_q <= 1'b0;
        end
        else
        begin
            dir_q <= dir_d;
            data_q <= data_d;
            opt_q <= opt_d;
            opt2_q <= opt2_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            pin_q <= pin_d;
            oe_q <= oe_d;
            wake_q <= wake_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign ce_pin_o = pin_q;
    assign ce_pin_oe_o = oe_q;
    assign wake_o = wake_q;
    // option bits exported for the analog side, gain boost included
    assign cmp1_en_o = opt_q[`CEPM_OPT_CMP1];
    assign cmp2_en_o = opt_q[`CEPM_OPT_CMP2];
    assign amp_en_o = opt_q[`CEPM_OPT_AMP];
    assign gain_boost_o = opt_q[`CEPM_OPT_GAIN];

    // assertions; the read checks look at the internal mux word, so they
    // hold every cycle and not only while a read of the data register is live

    // bus handshake: a taken request is answered once, then ack falls
    sequence s_bus_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_bus_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
    AST_ACK_LAT: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bus_take |=> s_bus_answer) else $error("ack not a single pulse");
    // read data stays zero outside the answer cycle
    AST_RDAT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");
    // a write with the low byte lane off leaves every register alone
    AST_SEL_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i)
        (!$past(rst_i) && $past(rd_go) && $past(req.we) && !$past(req.sel[0]))
        |-> $stable(dir_q) && $stable(data_q) && $stable(opt_q) && $stable(opt2_q))
        else $error("write with lane off landed");

    // port read selection
    AST_PLAIN: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == CEPM_PLAIN && !dir_q[0]) |-> port_rd[0] == ce_pin_i[0])
        else $error("plain read wrong");
    AST_PLAIN_ALL: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == CEPM_PLAIN || mode == CEPM_OTHER) |-> port_rd == plain_rd)
        else $error("plain read word wrong");
    AST_CMP1_B0: assert property (@(posedge clk_i) disable iff (rst_i)
        opt_q[`CEPM_OPT_CMP1] |-> port_rd[0] == cmp1_out_i) else $error("bit0 not cmp1");
    AST_CMP1_B1: assert property (@(posedge clk_i) disable iff (rst_i)
        (opt_q[`CEPM_OPT_CMP1] && !opt_q[`CEPM_OPT_CMP2] && !opt_q[`CEPM_OPT_BIT1_ZERO])
        |-> port_rd[1] == ce_pin_i[1]) else $error("bit1 not pin");
    AST_BIT1_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        (opt_q[`CEPM_OPT_CMP1] && opt_q[`CEPM_OPT_BIT1_ZERO] && mode != CEPM_OTHER)
        |-> !port_rd[1]) else $error("bit1 not zero");
    AST_CMP2_B2: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == CEPM_CMP && opt_q[`CEPM_OPT_CMP2]) |-> port_rd[2] == cmp2_out_i)
        else $error("bit2 not cmp2");
    AST_B3_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == CEPM_CMP && opt_q[`CEPM_OPT_CMP2] && !opt_q[`CEPM_OPT_BIT3_ZERO])
        |-> port_rd[3] == ce_pin_i[3]) else $error("bit3 not pin");
    AST_B3: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == CEPM_CMP && opt_q[`CEPM_OPT_CMP2])
        |-> port_rd[3] == (opt_q[`CEPM_OPT_BIT3_ZERO] ? 1'b0 : ce_pin_i[3]))
        else $error("bit3 wrong");
    AST_AMP_HI: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == CEPM_CMP_AMP |-> port_rd[3:2] == 2'h0) else $error("upper not zero");
    AST_AMP_B0: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == CEPM_CMP_AMP |-> port_rd[0] == cmp1_out_i) else $error("amp bit0 not cmp1");
    AST_AMP_B1: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == CEPM_CMP_AMP |-> port_rd[1] == (opt_q[`CEPM_OPT_BIT1_ZERO] ? 1'b0 : ce_pin_i[1]))
        else $error("amp bit1 wrong");
    // the amplifier mode needs comparator one and the amplifier, comparator two off
    AST_AMP_DECODE: assert property (@(posedge clk_i) disable iff (rst_i)
        (opt_q[`CEPM_OPT_CMP1] && opt_q[`CEPM_OPT_AMP] && !opt_q[`CEPM_OPT_CMP2])
        |-> mode == CEPM_CMP_AMP) else $error("amplifier mode not decoded");
    // untouched pairs keep the plain read
    AST_PAIR_LO: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == CEPM_CMP && !opt_q[`CEPM_OPT_CMP1]) |-> port_rd[1:0] == plain_rd[1:0])
        else $error("low pair substituted");
    AST_PAIR_HI: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == CEPM_CMP && !opt_q[`CEPM_OPT_CMP2]) |-> port_rd[3:2] == plain_rd[3:2])
        else $error("high pair substituted");
    // the data register answers with the mux word of the taking cycle
    AST_DATA_RD: assert property (@(posedge clk_i) disable iff (rst_i)
        (!$past(rst_i) && $past(rd_go && !req.we) && $past(req.adr) == `CEPM_ADDR_DATA)
        |-> wb_dat_o == {28'h0, $past(port_rd)}) else $error("data read word wrong");

    // pins, direction and wake; apart from AST_DIR_RST, checks reaching back past a reset edge are skipped
    AST_DIR_RST: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> dir_q == `CEPM_DIR_RST) else $error("direction not cleared");
    AST_WR_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
        (!$past(rst_i) && $past(wr) && $past(req.adr) == `CEPM_ADDR_DIR)
        |-> dir_q == $past(req.dat[3:0])) else $error("direction write lost");
    AST_DIR_OE: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> ce_pin_oe_o == $past(dir_q)) else $error("oe not direction");
    AST_FORCE: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> ((ce_pin_o & $past(force_high)) == $past(force_high)))
        else $error("force high lost");
    AST_PIN_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> ce_pin_o == ($past(data_q) | $past(force_high)))
        else $error("pin output wrong");
    AST_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> wake_o == |($past(e_wake_edge_i) & $past(wake_en)))
        else $error("wake wrong");
endmodule
`default_nettype wire

/* dv/cepm_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
// core model: classic single wishbone cycles
module cepm_cpu_model
    import cepm_pkg::*;
(
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output var cepm_wb_req_type req_o
);
    initial req_o = '0;
    // request held until ack is seen on a rising edge
    task automatic access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
        input logic [31:0] wdat, output logic [31:0] rdat);
    begin
        @(posedge clk_i);
        req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: wdat};
        do
            @(posedge clk_i);
        while (ack_i !== 1'b1);
        rdat = dat_i;
        // released lines flip, so nothing stale looks valid
        req_o <= ~req_o;
    end
    endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cepm_params.svh"
module testbench
    import cepm_pkg::*;
;
    typedef struct packed {
        logic [7:0] opt;
        logic [3:0] pin;
        logic [1:0] cmp;
        logic [3:0] exp;
    } cepm_row_type;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] pins = 4'h0;
    logic cmp1 = 1'b0;
    logic cmp2 = 1'b0;
    logic [3:0] wake_ev = 4'h0;
    cepm_wb_req_type req;
    logic [31:0] rdat_bus;
    logic [31:0] rd;
    logic ack, wake, c1_en, c2_en, amp_en, gain;
    logic [3:0] pin_o, pin_oe, pin_lvl;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    // options, pins, {cmp2, cmp1}, expected data read
    cepm_row_type rows [10] = '{
        '{8'h00, 4'hA, 2'b11, 4'hA},
        '{8'h01, 4'hA, 2'b01, 4'hB},
        '{8'h09, 4'hF, 2'b00, 4'hC},
        '{8'h02, 4'h9, 2'b10, 4'hD},
        '{8'h12, 4'hF, 2'b00, 4'h3},
        '{8'h03, 4'h0, 2'b11, 4'h5},
        '{8'h1B, 4'hF, 2'b11, 4'h5},
        '{8'h05, 4'hF, 2'b00, 4'h2},
        '{8'h0D, 4'hF, 2'b01, 4'h1},
        '{8'h04, 4'h6, 2'b11, 4'h6}
    };
    // pin wire: driven bits show the latch, others the outside level
    assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & pins);
    cepm_cpu_model cpu (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat_bus), .req_o(req));
    cepm_port_read_mux DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
        .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
        .wb_dat_o(rdat_bus), .wb_ack_o(ack), .ce_pin_i(pin_lvl), .ce_pin_o(pin_o),
        .ce_pin_oe_o(pin_oe), .cmp1_out_i(cmp1), .cmp2_out_i(cmp2),
        .e_wake_edge_i(wake_ev), .wake_o(wake), .cmp1_en_o(c1_en), .cmp2_en_o(c2_en),
        .amp_en_o(amp_en), .gain_boost_o(gain));
    initial forever #4 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] unused;
    begin
        cpu.access(1'b1, adr, 4'hF, d, unused);
    end
    endtask
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] v;
    begin
        cpu.access(1'b0, adr, 4'hF, 32'h0, v);
        chk(v, exp);
    end
    endtask
    task automatic summarize;
    begin
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    // hang guard, well above the expected hundred or so cycles
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            summarize();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(32'({pin_oe, pin_o, wake, gain}), 32'h0);
        rdchk(`CEPM_ADDR_DIR, 32'h0);
        $display("reset test done");
        foreach (rows[i])
        begin
            wr(`CEPM_ADDR_OPT, {24'h0, rows[i].opt});
            @(posedge clk_i);
            pins <= rows[i].pin;
            {cmp2, cmp1} <= rows[i].cmp;
            rdchk(`CEPM_ADDR_DATA, {28'h0, rows[i].exp});
            chk(32'({amp_en, c2_en, c1_en}), 32'(rows[i].opt[2:0]));
        end
        $display("table test done");
        // mixed directions: low pair reads latch, high pair reads pins
        wr(`CEPM_ADDR_OPT, 32'h0);
        wr(`CEPM_ADDR_DIR, 32'h3);
        wr(`CEPM_ADDR_DATA, 32'h1);
        pins <= 4'hC;
        rdchk(`CEPM_ADDR_DATA, 32'hD);
        chk(32'({pin_oe, pin_o}), 32'h31);
        // write with sel low and unmapped place are both ignored
        cpu.access(1'b1, `CEPM_ADDR_DIR, 4'h0, 32'hF, rd);
        rdchk(`CEPM_ADDR_DIR, 32'h3);
        wr(8'h30, 32'hF);
        rdchk(8'h30, 32'h0);
        wr(`CEPM_ADDR_OPT2, 32'h2A);
        // pin register follows the option one edge after the write lands
        @(posedge clk_i);
        chk(32'(pin_o), 32'hB);
        wake_ev <= 4'hD;
        repeat (2) @(posedge clk_i);
        chk(32'(wake), 32'h0);
        wake_ev <= 4'h2;
        repeat (2) @(posedge clk_i);
        chk(32'(wake), 32'h1);
        wr(`CEPM_ADDR_OPT, 32'h20);
        @(posedge clk_i);
        chk(32'({gain, amp_en}), 32'h2);
        // reset in mid-run clears direction again
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(`CEPM_ADDR_DIR, 32'h0);
        $display("awkward test done");
        summarize();
    end
endmodule
`default_nettype wire
